/* core/pmw_pkg.sv */
// package: register map, field layout and constants of the power mode / protect block
`default_nettype none
package pmw_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_PROTECT = 8'h00;
	localparam logic [7:0] OFF_CLOCK_DIV = 8'h04;
	localparam logic [7:0] OFF_PIN_CTRL = 8'h08;
	localparam logic [7:0] OFF_STANDBY = 8'h0c;
	localparam logic [7:0] OFF_OP_POWER = 8'h10;
	localparam logic [7:0] OFF_STOP_A = 8'h14;
	localparam logic [7:0] OFF_STOP_B = 8'h18;
	localparam logic [7:0] OFF_STOP_C = 8'h1c;
	localparam logic [7:0] OFF_STOP_D = 8'h20;
	localparam logic [7:0] OFF_MAIN_WAIT = 8'h24;
	localparam logic [7:0] OFF_SUB_WAIT = 8'h28;
	localparam logic [7:0] OFF_SW_RESET = 8'h2c;
	localparam logic [7:0] OFF_VCMP = 8'h30;
	localparam logic [7:0] OFF_STATUS = 8'h34;
	// protect register bit positions
	localparam int unsigned PRT_CLOCKGEN = 0;
	localparam int unsigned PRT_POWER_MODE = 1;
	localparam int unsigned PRT_VOLT_DET = 3;
	localparam logic [31:0] PROTECT_MASK = 32'h0000000b;
	// clock divider: seven 3-bit fields, one per nibble, ratio 1/2^n
	localparam int unsigned NUM_DOMAINS = 7;
	localparam int unsigned DOM_CORE = 0;
	localparam int unsigned DOM_BUS = 5;
	localparam logic [31:0] CLOCK_DIV_MASK = 32'h07777777;
	// pin control bits
	localparam int unsigned PIN_BUS_HIGH = 0;
	localparam int unsigned PIN_SDRAM_HIGH = 1;
	localparam logic [31:0] PIN_CTRL_MASK = 32'h00000003;
	localparam logic [31:0] STANDBY_MASK = 32'h00000003;
	localparam logic [31:0] BYTE_MASK = 32'h000000ff;
	// implemented module stop bits per register
	localparam logic [31:0] STOP_A_MASK = 32'h00010203;
	localparam logic [31:0] STOP_B_MASK = 32'h00108250;
	localparam logic [31:0] STOP_C_MASK = 32'h30880084;
	localparam logic [31:0] STOP_D_MASK = 32'h082a20ff;
	// reset values
	localparam logic [31:0] STOP_RESET = 32'h00000000;
	localparam logic [31:0] CLOCK_DIV_RESET = 32'h00000000;
	localparam logic [7:0] WAIT_RESET = 8'h00;
	// operating power control codes
	localparam logic [1:0] OPM_HIGH_SPEED = 2'h0;
	localparam logic [1:0] OPM_LOW_SPEED_1 = 2'h1;
	localparam logic [1:0] OPM_LOW_SPEED_2 = 2'h2;
	localparam logic [15:0] SW_RESET_KEY = 16'ha501;
	localparam int unsigned WAIT_STEP_CYCLES = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// low power mode selections and states
	localparam logic [1:0] LPM_SLEEP = 2'h0;
	localparam logic [1:0] LPM_ALL_STOP = 2'h1;
	localparam logic [1:0] LPM_SW_STANDBY = 2'h2;
	localparam logic [1:0] LPM_DEEP = 2'h3;
	typedef enum logic [2:0] {
		ST_RUN, ST_SLEEP, ST_ALL_STOP, ST_SW_STANDBY, ST_DEEP, ST_OSC_WAIT
	} pmw_state_t;
endpackage : pmw_pkg
`default_nettype wire

/* core/pmw_core.sv */
// power mode, clock division, module stop and register write protect block
// Contract
// - software sets the division ratio of the core, four peripheral, bus and flash clocks independently.
// - the bus clock pin carries the bus clock or a steady high, as software selects.
// - the SDRAM clock pin carries the bus clock or a steady high, as software selects.
// - each peripheral module has its own stop control that leaves the others running.
// - four low power modes exist: sleep, all-module clock stop, software standby, deep standby.
// - three operating power modes exist and hold in normal run, sleep and all-module stop.
// - stop register A bits 0, 1, 9 and 16 stop timer W unit 1, unit 0, timer unit 3 and ADC unit 1.
// - stop register B bits 4, 6, 9, 15, 20 stop serial, data op, event link, Ethernet, I2C.
// - stop register C bits 2, 7, 19, 23, 28, 29 stop ext RAM, standby RAM, CAC, QSPI, 2D, LCD.
// - stop register D bits 13, 19, 21, 27 stop SD slave, SD host, MMC host and security block.
// - stop register D bits 0 to 7 are eight generic module stop bits.
// - main and sub oscillator wait registers hold an 8-bit wait select in bits 0 to 7.
// - the clock generation protect bit gates writes to clock generation registers.
// - the power mode protect bit gates writes to power, stop, wait and software reset registers.
// - the voltage detect protect bit gates writes to voltage detection registers.
`default_nettype none
module pmw_core
	import pmw_pkg::*;
#(
	parameter int unsigned WAIT_STEP = WAIT_STEP_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// processor power requests
	input wire logic sleep_req,
	input wire logic wake_req,
	// clock enables: core, periph a..d, bus, flash
	output logic [NUM_DOMAINS-1:0] domain_tick,
	// clock output pins
	output logic bus_clock_out,
	output logic sdram_clock_out,
	// module clock enables, one per stop bit
	output logic [31:0] module_clk_en_a,
	output logic [31:0] module_clk_en_b,
	output logic [31:0] module_clk_en_c,
	output logic [31:0] module_clk_en_d,
	// power state
	output logic core_run,
	output logic periph_run,
	output logic osc_run,
	output logic deep_power_off,
	output logic [1:0] op_power_mode,
	// other controls
	output logic [7:0] main_wait_select,
	output logic [7:0] sub_wait_select,
	output logic [7:0] voltage_comparator_ctrl,
	output logic software_reset
);
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = data[8*b +: 8];
			end
		end
		return r & mask;
	endfunction : wmerge

	logic aw_ok_q, w_ok_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic do_write, wr_hit, rd_hit;
	logic [7:0] waddr, raddr;
	logic [31:0] rd_mux;
	logic [31:0] protect_q, clock_div_q, pin_ctrl_q, standby_q;
	logic [31:0] stop_a_q, stop_b_q, stop_c_q, stop_d_q;
	logic [1:0] op_mode_q;
	logic [7:0] main_wait_q, sub_wait_q, vcmp_q;
	logic sw_reset_q;
	logic wr_clk, wr_pwr, wr_vd;
	pmw_state_t state_q;
	logic [15:0] wait_cnt_q;
	logic [6:0] div_cnt_q;
	logic [NUM_DOMAINS-1:0] tick_q;
	logic bus_phase_q, bus_pin_q, sd_pin_q;
	logic [31:0] en_a_q, en_b_q, en_c_q, en_d_q;
	logic run_w, prun_w;

	// ---------------- axi4-lite slave ----------------
	assign s_axi_awready = !aw_ok_q && !bvalid_q;
	assign s_axi_wready = !w_ok_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign do_write = aw_ok_q && w_ok_q && !bvalid_q;
	assign waddr = {awaddr_q[7:2], 2'b00};
	assign raddr = {s_axi_araddr[7:2], 2'b00};
	assign wr_hit = (waddr <= OFF_VCMP);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_q <= 1'b0;
			w_ok_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			// a protected write still answers okay, it just does not land
			if (do_write) begin
				aw_ok_q <= 1'b0;
				w_ok_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_mux = 32'h00000000;
		case (raddr)
			OFF_PROTECT: rd_mux = protect_q;
			OFF_CLOCK_DIV: rd_mux = clock_div_q;
			OFF_PIN_CTRL: rd_mux = pin_ctrl_q;
			OFF_STANDBY: rd_mux = standby_q;
			OFF_OP_POWER: rd_mux = {30'h00000000, op_mode_q};
			OFF_STOP_A: rd_mux = stop_a_q;
			OFF_STOP_B: rd_mux = stop_b_q;
			OFF_STOP_C: rd_mux = stop_c_q;
			OFF_STOP_D: rd_mux = stop_d_q;
			OFF_MAIN_WAIT: rd_mux = {24'h000000, main_wait_q};
			OFF_SUB_WAIT: rd_mux = {24'h000000, sub_wait_q};
			OFF_SW_RESET: rd_mux = 32'h00000000;
			OFF_VCMP: rd_mux = {24'h000000, vcmp_q};
			OFF_STATUS: rd_mux = {28'h0000000, state_q == ST_OSC_WAIT, state_q};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ---------------- write protect groups ----------------
	assign wr_clk = do_write && protect_q[PRT_CLOCKGEN];
	assign wr_pwr = do_write && protect_q[PRT_POWER_MODE];
	assign wr_vd = do_write && protect_q[PRT_VOLT_DET];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			protect_q <= 32'h00000000;
		end else if (do_write && waddr == OFF_PROTECT) begin
			protect_q <= wmerge(protect_q, wdata_q, wstrb_q, PROTECT_MASK);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_div_q <= CLOCK_DIV_RESET;
			pin_ctrl_q <= 32'h00000000;
		end else if (wr_clk) begin
			if (waddr == OFF_CLOCK_DIV) begin
				clock_div_q <= wmerge(clock_div_q, wdata_q, wstrb_q, CLOCK_DIV_MASK);
			end
			if (waddr == OFF_PIN_CTRL) begin
				pin_ctrl_q <= wmerge(pin_ctrl_q, wdata_q, wstrb_q, PIN_CTRL_MASK);
			end
		end
	end

	// unimplemented stop bits stay zero, so they never gate anything
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stop_a_q <= STOP_RESET;
			stop_b_q <= STOP_RESET;
			stop_c_q <= STOP_RESET;
			stop_d_q <= STOP_RESET;
		end else if (wr_pwr) begin
			if (waddr == OFF_STOP_A) begin
				stop_a_q <= wmerge(stop_a_q, wdata_q, wstrb_q, STOP_A_MASK);
			end
			if (waddr == OFF_STOP_B) begin
				stop_b_q <= wmerge(stop_b_q, wdata_q, wstrb_q, STOP_B_MASK);
			end
			if (waddr == OFF_STOP_C) begin
				stop_c_q <= wmerge(stop_c_q, wdata_q, wstrb_q, STOP_C_MASK);
			end
			if (waddr == OFF_STOP_D) begin
				stop_d_q <= wmerge(stop_d_q, wdata_q, wstrb_q, STOP_D_MASK);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			standby_q <= 32'h00000000;
			op_mode_q <= OPM_HIGH_SPEED;
			main_wait_q <= WAIT_RESET;
			sub_wait_q <= WAIT_RESET;
		end else if (wr_pwr) begin
			if (waddr == OFF_STANDBY) begin
				standby_q <= wmerge(standby_q, wdata_q, wstrb_q, STANDBY_MASK);
			end
			// reserved code 3 is refused, the mode stays as it was
			if (waddr == OFF_OP_POWER && wstrb_q[0] && wdata_q[1:0] != 2'h3) begin
				op_mode_q <= wdata_q[1:0];
			end
			if (waddr == OFF_MAIN_WAIT && wstrb_q[0]) begin
				main_wait_q <= wdata_q[7:0];
			end
			if (waddr == OFF_SUB_WAIT && wstrb_q[0]) begin
				sub_wait_q <= wdata_q[7:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_reset_q <= 1'b0;
		end else begin
			sw_reset_q <= wr_pwr && waddr == OFF_SW_RESET && wstrb_q[1:0] == 2'h3
				&& wdata_q[15:0] == SW_RESET_KEY;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vcmp_q <= 8'h00;
		end else if (wr_vd && waddr == OFF_VCMP && wstrb_q[0]) begin
			vcmp_q <= wdata_q[7:0];
		end
	end

	// ---------------- low power state machine ----------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_RUN;
			wait_cnt_q <= 16'h0000;
		end else begin
			case (state_q)
				ST_RUN: begin
					if (sleep_req) begin
						case (standby_q[1:0])
							LPM_SLEEP: state_q <= ST_SLEEP;
							LPM_ALL_STOP: state_q <= ST_ALL_STOP;
							LPM_SW_STANDBY: state_q <= ST_SW_STANDBY;
							default: state_q <= ST_DEEP;
						endcase
					end
				end
				ST_SLEEP, ST_ALL_STOP: begin
					if (wake_req) begin
						state_q <= ST_RUN;
					end
				end
				// oscillators were off, so give them the programmed settle time
				ST_SW_STANDBY, ST_DEEP: begin
					if (wake_req) begin
						state_q <= ST_OSC_WAIT;
						wait_cnt_q <= 16'(main_wait_q * WAIT_STEP);
					end
				end
				ST_OSC_WAIT: begin
					if (wait_cnt_q == 16'h0000) begin
						state_q <= ST_RUN;
					end else begin
						wait_cnt_q <= wait_cnt_q - 16'h0001;
					end
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	assign run_w = (state_q == ST_RUN);
	assign prun_w = run_w || state_q == ST_SLEEP;
	assign core_run = run_w;
	assign periph_run = prun_w;
	assign osc_run = !(state_q == ST_SW_STANDBY || state_q == ST_DEEP);
	assign deep_power_off = (state_q == ST_DEEP);
	assign op_power_mode = op_mode_q;
	assign main_wait_select = main_wait_q;
	assign sub_wait_select = sub_wait_q;
	assign voltage_comparator_ctrl = vcmp_q;
	assign software_reset = sw_reset_q;

	// ---------------- clock division ----------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_q <= 7'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 7'h01;
		end
	end

	// one shared counter keeps all domains phase-aligned to each other
	for (genvar i = 0; i < NUM_DOMAINS; i++) begin : g_div
		logic [7:0] m;
		assign m = (8'h01 << clock_div_q[4*i +: 3]) - 8'h01;
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				tick_q[i] <= 1'b0;
			end else begin
				tick_q[i] <= ((div_cnt_q & m[6:0]) == m[6:0])
					&& (i == DOM_CORE ? run_w : prun_w);
			end
		end
	end
	assign domain_tick = tick_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_phase_q <= 1'b0;
			bus_pin_q <= 1'b1;
			sd_pin_q <= 1'b1;
		end else begin
			if (tick_q[DOM_BUS]) begin
				bus_phase_q <= !bus_phase_q;
			end
			bus_pin_q <= pin_ctrl_q[PIN_BUS_HIGH] ? 1'b1 : bus_phase_q;
			sd_pin_q <= pin_ctrl_q[PIN_SDRAM_HIGH] ? 1'b1 : bus_phase_q;
		end
	end
	assign bus_clock_out = bus_pin_q;
	assign sdram_clock_out = sd_pin_q;

	// ---------------- module clock gating ----------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_a_q <= 32'h00000000;
			en_b_q <= 32'h00000000;
			en_c_q <= 32'h00000000;
			en_d_q <= 32'h00000000;
		end else begin
			en_a_q <= prun_w ? ~stop_a_q : 32'h00000000;
			en_b_q <= prun_w ? ~stop_b_q : 32'h00000000;
			en_c_q <= prun_w ? ~stop_c_q : 32'h00000000;
			en_d_q <= prun_w ? ~stop_d_q : 32'h00000000;
		end
	end
	assign module_clk_en_a = en_a_q;
	assign module_clk_en_b = en_b_q;
	assign module_clk_en_c = en_c_q;
	assign module_clk_en_d = en_d_q;

	// ---------------- assertions ----------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_clkgen_locked;
		do_write && waddr == OFF_CLOCK_DIV && !protect_q[PRT_CLOCKGEN] |=> $stable(clock_div_q);
	endproperty
	a_clkgen_locked: assert property (p_clkgen_locked) else $error("clock div changed while locked");

	property p_stop_locked;
		do_write && waddr == OFF_STOP_A && !protect_q[PRT_POWER_MODE] |=> $stable(stop_a_q);
	endproperty
	a_stop_locked: assert property (p_stop_locked) else $error("stop reg changed while locked");

	property p_vd_locked;
		do_write && waddr == OFF_VCMP && !protect_q[PRT_VOLT_DET] |=> $stable(vcmp_q);
	endproperty
	a_vd_locked: assert property (p_vd_locked) else $error("comparator changed while locked");

	property p_wait_lands;
		do_write && waddr == OFF_MAIN_WAIT && protect_q[PRT_POWER_MODE] && wstrb_q[0]
			|=> main_wait_q == $past(wdata_q[7:0]);
	endproperty
	a_wait_lands: assert property (p_wait_lands) else $error("wait write lost");

	property p_bus_high;
		pin_ctrl_q[PIN_BUS_HIGH] ##1 pin_ctrl_q[PIN_BUS_HIGH] |-> bus_clock_out;
	endproperty
	a_bus_high: assert property (p_bus_high) else $error("bus pin not high");

	property p_sd_high;
		pin_ctrl_q[PIN_SDRAM_HIGH] ##1 pin_ctrl_q[PIN_SDRAM_HIGH] |-> sdram_clock_out;
	endproperty
	a_sd_high: assert property (p_sd_high) else $error("sdram pin not high");

	property p_stop_gates;
		stop_a_q[9] |=> !module_clk_en_a[9];
	endproperty
	a_stop_gates: assert property (p_stop_gates) else $error("stopped module clocked");

	property p_stop_indep;
		prun_w && stop_b_q[4] && !stop_b_q[6] ##1 prun_w |-> module_clk_en_b[6];
	endproperty
	a_stop_indep: assert property (p_stop_indep) else $error("neighbour module stopped");

	property p_sleep_split;
		state_q == ST_SLEEP |-> !core_run && periph_run && osc_run;
	endproperty
	a_sleep_split: assert property (p_sleep_split) else $error("sleep power split wrong");

	property p_div_one;
		clock_div_q[2:0] == 3'h0 && run_w [*2] |-> domain_tick[DOM_CORE];
	endproperty
	a_div_one: assert property (p_div_one) else $error("core tick missing at ratio 1");

	property p_op_legal;
		op_power_mode != 2'h3;
	endproperty
	a_op_legal: assert property (p_op_legal) else $error("reserved power mode");

	c_sleep_wake: cover property (state_q == ST_SLEEP ##[1:20] state_q == ST_RUN);
	c_osc_wait: cover property (state_q == ST_OSC_WAIT ##1 state_q == ST_RUN);
	c_locked_write: cover property (do_write && !protect_q[PRT_POWER_MODE]);
	c_sw_reset: cover property (software_reset);
endmodule : pmw_core
`default_nettype wire

/* test/pmw_core_tb.sv */
// self-checking bench for the power mode, clock division and write protect block
`default_nettype none
module pmw_core_tb import pmw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] addr; logic [31:0] wdata; logic [31:0] rd; logic [31:0] out;} pmw_row_t;
	logic aclk, aresetn, sleep_req, wake_req;
	logic [7:0] awaddr, araddr, mwait, swait, vcmp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, en_a, en_b, en_c, en_d, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, op_mode, resp;
	logic [NUM_DOMAINS-1:0] tick;
	logic bus_pin, sdram_pin, core_run, periph_run, osc_run, deep_off, sw_rst;
	int err_count, cmp_count, n, tc, ta, tb, pc, sc;
	int sw_cnt = 0;
	pmw_row_t rows [13] = '{
		'{OFF_STOP_A, 32'hffffffff, STOP_A_MASK, ~STOP_A_MASK},
		'{OFF_STOP_B, 32'hffffffff, STOP_B_MASK, ~STOP_B_MASK},
		'{OFF_STOP_C, 32'hffffffff, STOP_C_MASK, ~STOP_C_MASK},
		'{OFF_STOP_D, 32'hffffffff, STOP_D_MASK, ~STOP_D_MASK},
		'{OFF_STOP_D, 32'h000000ff, 32'h000000ff, 32'hffffff00},
		'{OFF_STOP_A, 32'h00000000, 32'h00000000, 32'hffffffff},
		'{OFF_STOP_B, 32'h00008010, 32'h00008010, 32'hffff7fef},
		'{OFF_MAIN_WAIT, 32'h000001a5, 32'h000000a5, 32'h000000a5},
		'{OFF_SUB_WAIT, 32'h0000005a, 32'h0000005a, 32'h0000005a},
		'{OFF_VCMP, 32'h0000003c, 32'h0000003c, 32'h0000003c},
		'{OFF_OP_POWER, 32'h00000001, 32'h00000001, 32'h00000001},
		'{OFF_OP_POWER, 32'h00000002, 32'h00000002, 32'h00000002},
		'{OFF_OP_POWER, 32'h00000000, 32'h00000000, 32'h00000000}};

	// short wait step keeps the oscillator wait under a few hundred cycles
	pmw_core #(.WAIT_STEP(1)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sleep_req(sleep_req), .wake_req(wake_req), .domain_tick(tick),
		.bus_clock_out(bus_pin), .sdram_clock_out(sdram_pin),
		.module_clk_en_a(en_a), .module_clk_en_b(en_b), .module_clk_en_c(en_c),
		.module_clk_en_d(en_d), .core_run(core_run), .periph_run(periph_run),
		.osc_run(osc_run), .deep_power_off(deep_off), .op_power_mode(op_mode),
		.main_wait_select(mwait), .sub_wait_select(swait),
		.voltage_comparator_ctrl(vcmp), .software_reset(sw_rst));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (sw_rst === 1'b1) sw_cnt++;
	end

	task end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task timeout;
		err_count++;
		$display("CHECK FAILED handshake expected answer seen none");
		end_sim();
	endtask : timeout

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// requests are held until their own ready is seen; the bench never assumes a latency
	task axi_wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
		int k;
		logic xa, xw, xb;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= dat;
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(negedge aclk);
			xa = awvalid && awready;
			xw = wvalid && wready;
			xb = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (xa) awvalid <= 1'b0;
			if (xw) wvalid <= 1'b0;
			if (xb) begin
				bready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
		int k;
		logic xa, xb;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(negedge aclk);
			xa = arvalid && arready;
			xb = rvalid;
			dat = rdata;
			rs = rresp;
			@(posedge aclk);
			if (xa) arvalid <= 1'b0;
			if (xb) begin
				rready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask : axi_rd

	task wr(input logic [7:0] a, input logic [31:0] dat);
		axi_wr(a, dat, resp);
		chk("write response", {30'h0, RESP_OKAY}, {30'h0, resp});
	endtask : wr

	// counts ticks and pin edges over a window of whole divider periods
	task sample(input int cyc);
		logic lb, ls;
		tc = 0;
		ta = 0;
		tb = 0;
		pc = 0;
		sc = 0;
		@(negedge aclk);
		lb = bus_pin;
		ls = sdram_pin;
		repeat (cyc) begin
			@(negedge aclk);
			tc += (tick[DOM_CORE] === 1'b1);
			ta += (tick[1] === 1'b1);
			tb += (tick[DOM_BUS] === 1'b1);
			pc += (bus_pin !== lb);
			sc += (sdram_pin !== ls);
			lb = bus_pin;
			ls = sdram_pin;
		end
	endtask : sample

	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready, sleep_req, wake_req} = '0;
		err_count = 0;
		cmp_count = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk("module_clk_en_a", 32'hffffffff, en_a);
		axi_rd(OFF_STOP_C, d, resp);
		chk("module_stop_c reset", STOP_RESET, d);
		$display("test reset done");
		wr(OFF_STOP_A, 32'hffffffff);
		axi_rd(OFF_STOP_A, d, resp);
		chk("module_stop_a locked", 32'h0, d);
		wr(OFF_VCMP, 32'h0000003c);
		chk("voltage_comparator_ctrl locked", 32'h0, {24'h0, vcmp});
		wr(OFF_CLOCK_DIV, 32'h07777777);
		wr(OFF_PIN_CTRL, 32'h00000003);
		sample(8);
		chk("bus pin runs while locked", 32'd8, pc);
		wr(OFF_SW_RESET, {16'h0, SW_RESET_KEY});
		repeat (2) @(posedge aclk);
		chk("software reset locked", 32'h0, sw_cnt);
		$display("test locked groups done");
		wr(OFF_PROTECT, PROTECT_MASK);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			axi_rd(rows[i].addr, d, resp);
			chk("register readback", rows[i].rd, d);
			@(negedge aclk);
			case (rows[i].addr)
				OFF_STOP_A: d = en_a;
				OFF_STOP_B: d = en_b;
				OFF_STOP_C: d = en_c;
				OFF_STOP_D: d = en_d;
				OFF_MAIN_WAIT: d = {24'h0, mwait};
				OFF_SUB_WAIT: d = {24'h0, swait};
				OFF_VCMP: d = {24'h0, vcmp};
				default: d = {30'h0, op_mode};
			endcase
			chk("port after write", rows[i].out, d);
		end
		wr(OFF_OP_POWER, 32'h00000003);
		chk("op_power_mode code 3", 32'h0, {30'h0, op_mode});
		$display("test register table done");
		wr(OFF_CLOCK_DIV, 32'h00000031);
		sample(16);
		chk("core ticks per 16", 32'd8, tc);
		chk("periph a ticks per 16", 32'd2, ta);
		chk("bus ticks per 16", 32'd16, tb);
		sample(8);
		chk("bus pin toggles", 32'h1, {31'h0, pc != 0});
		chk("sdram pin toggles", 32'h1, {31'h0, sc != 0});
		wr(OFF_PIN_CTRL, 32'h00000003);
		repeat (2) @(posedge aclk);
		sample(8);
		chk("pins held high", 32'h3, {30'h0, bus_pin, sdram_pin});
		chk("pin edges while high", 32'h0, pc + sc);
		$display("test clocks and pins done");
		for (int m = 0; m < 4; m++) begin
			wr(OFF_STANDBY, m);
			@(posedge aclk);
			sleep_req <= 1'b1;
			@(posedge aclk);
			sleep_req <= 1'b0;
			@(posedge aclk);
			@(negedge aclk);
			chk("core_run in low power", 32'h0, {31'h0, core_run});
			chk("periph_run in low power", {31'h0, m == 0}, {31'h0, periph_run});
			chk("osc_run in low power", {31'h0, m < 2}, {31'h0, osc_run});
			chk("deep_power_off", {31'h0, m == 3}, {31'h0, deep_off});
			chk("module_clk_en_b", (m == 0) ? 32'hffff7fef : 32'h0, en_b);
			axi_rd(OFF_STATUS, d, resp);
			chk("power state code", 32'(m + 1), d);
			@(posedge aclk);
			wake_req <= 1'b1;
			for (n = 0; n < 400; n++) begin
				@(negedge aclk);
				if (core_run === 1'b1) break;
			end
			@(posedge aclk);
			wake_req <= 1'b0;
			if (n == 400) timeout();
			// standby modes must sit out the oscillator wait of 0xa5 units
			chk("oscillator wait observed", {31'h0, m >= 2}, {31'h0, n > 100});
		end
		$display("test low power modes done");
		axi_rd(8'h3c, d, resp);
		chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		chk("unmapped read data", 32'h0, d);
		axi_wr(8'h38, 32'hffffffff, resp);
		chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		wr(OFF_SW_RESET, 32'h0000a500);
		repeat (2) @(posedge aclk);
		chk("software reset wrong key", 32'h0, sw_cnt);
		wr(OFF_SW_RESET, {16'h0, SW_RESET_KEY});
		repeat (2) @(posedge aclk);
		chk("software reset pulses", 32'h1, sw_cnt);
		$display("test errors and software reset done");
		end_sim();
	end
endmodule : pmw_core_tb
`default_nettype wire
